// ---- logic/erxf_pkg.sv ----
// package: register map, field layout and types of the receive filter block
package erxf_pkg;

    // ========================================================================
    // register map
    localparam logic [3:0]  CFG_OFFSET       = 4'h0;
    localparam logic [3:0]  RXCTL_OFFSET     = 4'h4;
    localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
    localparam logic [31:0] CFG_WRITE_MASK   = 32'h0000_dfff;

    // ========================================================================
    // field positions
    localparam int HASH_EN_BIT   = 15;
    localparam int WAKE_EN_BIT   = 14;
    localparam int INVERT_BIT    = 12;
    localparam int MODE_LSB      = 8;
    localparam int RECEIVE_ENABLE_BIT      = 0;

    // ========================================================================
    // pattern mode codes
    localparam logic [3:0] PM_OFF       = 4'h0;
    localparam logic [3:0] PM_CSUM      = 4'h1;
    localparam logic [3:0] PM_STATION0  = 4'h2;
    localparam logic [3:0] PM_STATION1  = 4'h3;
    localparam logic [3:0] PM_UNICAST0  = 4'h4;
    localparam logic [3:0] PM_UNICAST1  = 4'h5;
    localparam logic [3:0] PM_BCAST0    = 4'h6;
    localparam logic [3:0] PM_BCAST1    = 4'h7;
    localparam logic [3:0] PM_HASH      = 4'h8;
    localparam logic [3:0] PM_WAKE      = 4'h9;

    // per-frame results from the receive datapath
    typedef struct packed {
        logic valid;
        logic checksumMatch;
        logic isStation;
        logic isUnicast;
        logic isBroadcast;
        logic isMulticast;
        logic hashHit;
        logic wakeupPacket;
    } erxf_frame_t;

    // decision handed back per frame
    typedef struct packed {
        logic valid;
        logic patternMatch;
        logic hashFilterOn;
        logic wakeFilterOn;
    } erxf_result_t;

    typedef struct packed {
        logic [15:0]  cfg;
        logic         receiveEnable;
        logic [31:0]  readData;
        erxf_result_t result;
    } erxf_state_t;

endpackage : erxf_pkg

// ---- logic/erxf_filter.sv ----
// receive filter configuration register and pattern-match decision
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module erxf_filter (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic [3:0]             regAddr,
    input  wire logic [31:0]            regWriteData,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic      [31:0]            regReadData,
    input  wire erxf_pkg::erxf_frame_t  frameIn,
    output erxf_pkg::erxf_result_t      resultOut,
    output logic      [7:0]             acceptEnables,
    output logic                        receiveEnable
);

    // ========================================================================
    // state
    erxf_pkg::erxf_state_t state;
    erxf_pkg::erxf_state_t next_state;
    logic                  xorTerm;
    logic                  qualify;
    logic [3:0]            mode;

    assign mode = state.cfg[erxf_pkg::MODE_LSB +: 4];

    // ========================================================================
    // decision
    always_comb begin
        // the transmit path has no port here, so nothing can leak into it
        xorTerm = state.cfg[erxf_pkg::INVERT_BIT] ^ frameIn.checksumMatch;
        unique case (mode)
            erxf_pkg::PM_OFF:      qualify = 1'b0;
            erxf_pkg::PM_CSUM:     qualify = 1'b1;
            erxf_pkg::PM_STATION0,
            erxf_pkg::PM_STATION1: qualify = frameIn.isStation;
            erxf_pkg::PM_UNICAST0,
            erxf_pkg::PM_UNICAST1: qualify = frameIn.isUnicast;
            erxf_pkg::PM_BCAST0,
            erxf_pkg::PM_BCAST1:   qualify = frameIn.isBroadcast;
            erxf_pkg::PM_HASH:     qualify = frameIn.hashHit;
            erxf_pkg::PM_WAKE:     qualify = frameIn.wakeupPacket;
            // codes above 1001 are undefined; treated as no match
            default:               qualify = 1'b0;
        endcase
    end

    // ========================================================================
    // next state
    always_comb begin
        next_state = state;
        next_state.readData = 32'h0000_0000;
        if (regWrite) begin
            unique case (regAddr)
                erxf_pkg::CFG_OFFSET: begin
                    // writes to bits 13 and 31-16 are dropped
                    next_state.cfg = regWriteData[15:0] & erxf_pkg::CFG_WRITE_MASK[15:0];
                end
                erxf_pkg::RXCTL_OFFSET: begin
                    next_state.receiveEnable = regWriteData[erxf_pkg::RECEIVE_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                erxf_pkg::CFG_OFFSET:   next_state.readData = {16'h0000, state.cfg};
                erxf_pkg::RXCTL_OFFSET: next_state.readData = {31'h0, state.receiveEnable};
                default:                next_state.readData = 32'h0000_0000;
            endcase
        end
        // per-frame result, one cycle after the datapath offers it
        next_state.result.valid        = frameIn.valid;
        next_state.result.patternMatch = frameIn.valid & xorTerm & qualify;
        next_state.result.hashFilterOn = state.cfg[erxf_pkg::HASH_EN_BIT];
        next_state.result.wakeFilterOn = state.cfg[erxf_pkg::WAKE_EN_BIT];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign regReadData   = state.readData;
    assign resultOut     = state.result;
    assign acceptEnables = state.cfg[7:0];
    assign receiveEnable = state.receiveEnable;

    // ========================================================================
    // checks
    property p_unimpl_zero;
        @(posedge mclk) disable iff (!resetn)
        $past(regRead) && $past(regAddr) == erxf_pkg::CFG_OFFSET
            |-> regReadData[31:16] == 16'h0000 && !regReadData[13];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

    property p_mode_off;
        @(posedge mclk) disable iff (!resetn)
        $past(mode) == 4'h0 |-> !resultOut.patternMatch;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("match reported while disabled");

    property p_mode_csum;
        @(posedge mclk) disable iff (!resetn)
        $past(mode) == 4'h1 && $past(frameIn.valid)
            |-> resultOut.patternMatch == ($past(state.cfg[12]) ^ $past(frameIn.checksumMatch));
    endproperty
    a_mode_csum: assert property (p_mode_csum) else $error("mode 1 result wrong");

    property p_xor_both;
        @(posedge mclk) disable iff (!resetn)
        $past(state.cfg[12]) && $past(frameIn.checksumMatch) |-> !resultOut.patternMatch;
    endproperty
    a_xor_both: assert property (p_xor_both) else $error("xor true with both inputs set");

    property p_station;
        @(posedge mclk) disable iff (!resetn)
        ($past(mode) == 4'h2 || $past(mode) == 4'h3) && !$past(frameIn.isStation)
            |-> !resultOut.patternMatch;
    endproperty
    a_station: assert property (p_station) else $error("station mode matched non-station");

    property p_unicast;
        @(posedge mclk) disable iff (!resetn)
        ($past(mode) == 4'h4 || $past(mode) == 4'h5) && !$past(frameIn.isUnicast)
            |-> !resultOut.patternMatch;
    endproperty
    a_unicast: assert property (p_unicast) else $error("unicast mode matched non-unicast");

    property p_bcast;
        @(posedge mclk) disable iff (!resetn)
        ($past(mode) == 4'h6 || $past(mode) == 4'h7) && !$past(frameIn.isBroadcast)
            |-> !resultOut.patternMatch;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast mode matched other frame");

    property p_hash;
        @(posedge mclk) disable iff (!resetn)
        $past(mode) == 4'h8 && $past(frameIn.valid) && $past(frameIn.hashHit)
            && ($past(state.cfg[12]) ^ $past(frameIn.checksumMatch))
            |-> resultOut.patternMatch;
    endproperty
    a_hash: assert property (p_hash) else $error("hash mode missed a hit");

    property p_wake;
        @(posedge mclk) disable iff (!resetn)
        $past(mode) == 4'h9 && $past(frameIn.valid) && $past(frameIn.wakeupPacket)
            && ($past(state.cfg[12]) ^ $past(frameIn.checksumMatch))
            |-> resultOut.patternMatch;
    endproperty
    a_wake: assert property (p_wake) else $error("wake mode missed a packet");

    // the enables reach resultOut one cycle after the config register takes the write
    property p_enables;
        @(posedge mclk) disable iff (!resetn)
        $past(regWrite) && $past(regAddr) == erxf_pkg::CFG_OFFSET
            |-> ##1 (resultOut.hashFilterOn == $past(regWriteData[15], 2)
                     && resultOut.wakeFilterOn == $past(regWriteData[14], 2));
    endproperty
    a_enables: assert property (p_enables) else $error("filter enable not applied");

    c_csum_hit:  cover property (@(posedge mclk) mode == 4'h1 && frameIn.valid ##1 resultOut.patternMatch);
    c_hash_hit:  cover property (@(posedge mclk) mode == 4'h8 ##1 resultOut.patternMatch);
    c_wake_hit:  cover property (@(posedge mclk) mode == 4'h9 ##1 resultOut.patternMatch);
    c_inverted:  cover property (@(posedge mclk) state.cfg[12] ##1 resultOut.patternMatch);

endmodule : erxf_filter

`default_nettype wire

// ---- bench/erxf_rx_source.sv ----
// receive datapath model: hands the filter one frame of match results per call
`timescale 1ns/1ps
`default_nettype none

module erxf_rx_source (
    input  wire logic             mclk,
    output erxf_pkg::erxf_frame_t frame
);
    initial frame = '0;

    // ========================================================================
    // frame delivery
    // indications flip once valid drops so that a stale sample never looks right
    task automatic send(input logic [6:0] ind);
        @(posedge mclk);
        frame <= {1'b1, ind};
        @(posedge mclk);
        frame <= {1'b0, ~ind};
    endtask : send
endmodule : erxf_rx_source

`default_nettype wire

// ---- bench/erxf_filter_tb.sv ----
// self-checking bench of the receive filter: register access and pattern decisions
`timescale 1ns/1ps
`default_nettype none

module erxf_filter_tb;
    logic                   mclk;
    logic                   resetn;
    logic                   regWrite;
    logic                   regRead;
    logic [3:0]             regAddr;
    logic [31:0]            regWriteData;
    logic [31:0]            regReadData;
    logic [31:0]            rdata;
    erxf_pkg::erxf_frame_t  frameIn;
    erxf_pkg::erxf_result_t resultOut;
    logic [7:0]             acceptEnables;
    logic                   receiveEnable;
    int                     badCount;
    int                     checkCount;

    erxf_filter uut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .frameIn(frameIn), .resultOut(resultOut),
        .acceptEnables(acceptEnables), .receiveEnable(receiveEnable));
    erxf_rx_source src (.mclk(mclk), .frame(frameIn));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ========================================================================
    // access and compare tasks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regReadData;
    endtask : rd

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1

    function automatic logic expectPm(input logic [3:0] m, input logic inv,
                                      input logic [6:0] f);
        logic x;
        x = inv ^ f[6];
        case (m)
            4'h1:       return x;
            4'h2, 4'h3: return x & f[5];
            4'h4, 4'h5: return x & f[4];
            4'h6, 4'h7: return x & f[3];
            4'h8:       return x & f[1];
            4'h9:       return x & f[0];
            default:    return 1'b0;
        endcase
    endfunction : expectPm

    task automatic summarize();
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize

    // ========================================================================
    // test sequence
    initial begin
        resetn = 1'b0;
        regAddr = 4'h0;
        regWriteData = 32'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rd(4'h0, rdata);
        chk32(rdata, 32'h0000_0000);
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, rdata);
        chk32(rdata, 32'h0000_dfff);
        chk32({24'h0, acceptEnables}, 32'h0000_00ff);
        chk1(resultOut.hashFilterOn, 1'b1);
        chk1(resultOut.wakeFilterOn, 1'b1);
        wr(4'h0, 32'h0000_40a5);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, rdata);
        chk32(rdata, 32'h0000_0000);
        rd(4'h0, rdata);
        chk32(rdata, 32'h0000_40a5);
        chk1(resultOut.hashFilterOn, 1'b0);
        chk1(resultOut.wakeFilterOn, 1'b1);
        wr(4'h4, 32'h0000_0001);
        #1 chk1(receiveEnable, 1'b1);
        wr(4'h4, 32'h0000_0000);
        // every mode, both polarities, all indication mixes; enables cleared when inverted
        for (int m = 0; m < 16; m++) begin
            for (int v = 0; v < 2; v++) begin
                wr(4'h0, {16'h0, ~v[0], ~v[0], 1'b0, v[0], m[3:0], 8'h00});
                for (int k = 0; k < 128; k++) begin
                    src.send(k[6:0]);
                    #1 chk1(resultOut.valid, 1'b1);
                    chk1(resultOut.patternMatch, expectPm(m[3:0], v[0], k[6:0]));
                end
            end
        end
        @(posedge mclk);
        #1 chk1(resultOut.valid, 1'b0);
        summarize();
    end

    initial begin
        #(25 * 20000);
        badCount++;
        summarize();
    end
endmodule : erxf_filter_tb

`default_nettype wire
